// *** design/rtcc_ctrl.sv ***
// Control and status registers of the calendar real-time counter
// Functional notes
// R1: Power bit stops or enables whole counter
// R2: Select bit picks subclock or baud clock
// R3: Change clock select only while powered off
// R4: Keep clock select zero in backup mode
// R5: Registers clear only on backup power-on reset
// R6: Run bit stops or allows time counting
// R7: Never write run bit from one to zero
// R8: One-hertz pin follows enable within two ticks
// R9: Clock pin carries 32.768 kHz when enabled
// R10: Format bit picks 12 or 24 hours
// R11: Rewrite hour count after changing format
// R12: Fixed-cycle select picks interrupt period
// R13: Alarm enable gates alarm interrupt on match
// R14: Wait request halts second-to-year counting
// R15: Wait status shows wait has taken effect
// R16: Overflow during wait kept, applied, or discarded
// R17: Wait status holds until counter writes finish
// R18: Interval enable gates interval interrupt
// R19: Divided pin enable and frequency select
// R20: Divided pin starts or stops within two ticks
// R21: Interval select sets period 2^6 to 2^12
// R22: Backup mode silences interrupts and pin outputs
// R23: Control bits staged into counting-tick domain
`timescale 1ns/1ps
module rtcc_ctrl (
	input wire logic ref_clk,
	input wire logic rst,
	input wire rtcc_pkg::rtcc_bus_req_s bus_req,
	output logic [7:0] rd_data,
	input wire logic sub_clk,
	input wire logic brg_clk,
	input wire logic backup_mode_set,
	input wire logic alarm_match,
	input wire logic minute_start,
	input wire logic hour_start,
	input wire logic day_start,
	input wire logic month_start,
	input wire logic second_write,
	input wire logic counter_write_busy,
	output rtcc_pkg::rtcc_pins_s pins,
	output rtcc_pkg::rtcc_irqs_s irqs,
	output logic sec_count_up,
	output logic time_count_en,
	output logic counter_hold,
	output logic rtc_power_on,
	output logic count_clock_select,
	output logic hour_format_24
);
	rtcc_pkg::rtcc_state_s st_reg;
	rtcc_pkg::rtcc_state_s st_next;
	logic tick;
	logic running;
	logic ovf;
	logic wait_status;
	logic fc_hit;
	logic [14:0] int_mask;

	function automatic logic [14:0] interval_mask(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel >= rtcc_pkg::INTERVAL_TOP_SEL) ? rtcc_pkg::INTERVAL_TOP_SEL : sel;
		return (rtcc_pkg::INTERVAL_BASE << s) - 15'h0001;
	endfunction

	// Counting tick from a rising edge of the chosen count clock
	assign tick = st_reg.ctrl0[rtcc_pkg::CLK_SEL_BIT] ? (brg_clk & ~st_reg.brg_prev) :
		(sub_clk & ~st_reg.sub_prev); // R2
	assign running = st_reg.ctrl0[rtcc_pkg::POWER_ON_BIT] & st_reg.ctrl1[rtcc_pkg::RUN_BIT]; // R1 R6
	assign ovf = tick & running & (&st_reg.presc);
	assign wait_status = (st_reg.wstate != rtcc_pkg::RTCC_RUN); // R15 R17
	assign int_mask = interval_mask(st_reg.ctrl3[rtcc_pkg::SEL_MSB:rtcc_pkg::SEL_LSB]);

	always_comb
	begin
		st_next = st_reg;
		fc_hit = 1'b0;
		st_next.sub_prev = sub_clk;
		st_next.brg_prev = brg_clk;
		st_next.rdata = 8'h00;
		st_next.sec_up = 1'b0;
		// Bus writes; only the documented bits are storable
		if (bus_req.wr)
		begin
			unique case (bus_req.addr)
				rtcc_pkg::ADDR_POWER_CLOCK:
					st_next.ctrl0 = bus_req.wdata & rtcc_pkg::MASK_POWER_CLOCK;
				rtcc_pkg::ADDR_RUN_OUT_CYCLE:
					st_next.ctrl1 = bus_req.wdata & rtcc_pkg::MASK_RUN_OUT_CYCLE;
				rtcc_pkg::ADDR_ALARM_WAIT:
					st_next.ctrl2 = bus_req.wdata & rtcc_pkg::MASK_ALARM_WAIT;
				rtcc_pkg::ADDR_INTERVAL_OUT:
					st_next.ctrl3 = bus_req.wdata & rtcc_pkg::MASK_INTERVAL_OUT;
				default:
					st_next.rdata = 8'h00;
			endcase
		end
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				rtcc_pkg::ADDR_POWER_CLOCK:
					st_next.rdata = st_reg.ctrl0;
				rtcc_pkg::ADDR_RUN_OUT_CYCLE:
					st_next.rdata = st_reg.ctrl1;
				rtcc_pkg::ADDR_ALARM_WAIT:
				begin
					st_next.rdata = st_reg.ctrl2;
					st_next.rdata[rtcc_pkg::WAIT_STAT_BIT] = wait_status; // R15
				end
				rtcc_pkg::ADDR_INTERVAL_OUT:
					st_next.rdata = st_reg.ctrl3;
				default:
					st_next.rdata = 8'h00;
			endcase
		end
		// Controls staged through two counting ticks, bounding latency at two
		if (tick)
		begin
			st_next.sync1[rtcc_pkg::SY_WAIT] = st_reg.ctrl2[rtcc_pkg::WAIT_REQ_BIT]; // R23
			st_next.sync1[rtcc_pkg::SY_ONE_HZ] = st_reg.ctrl1[rtcc_pkg::ONE_HZ_BIT]; // R23
			st_next.sync1[rtcc_pkg::SY_CLK32K] = st_reg.ctrl1[rtcc_pkg::CLK32K_BIT]; // R23
			st_next.sync1[rtcc_pkg::SY_DIV_EN] = st_reg.ctrl3[rtcc_pkg::DIV_EN_BIT]; // R23
			st_next.sync1[rtcc_pkg::SY_DIV_SEL] = st_reg.ctrl3[rtcc_pkg::DIV_FREQ_BIT]; // R23
			st_next.sync2 = st_reg.sync1; // R23
		end
		// Prescaler is held clear while powered off so a restart begins a full second
		if (!st_reg.ctrl0[rtcc_pkg::POWER_ON_BIT])
			st_next.presc = 15'h0000; // R1
		else if (tick && running)
			st_next.presc = st_reg.presc + 15'h0001; // R6
		// Wait handshake
		unique case (st_reg.wstate)
			rtcc_pkg::RTCC_RUN:
				if (st_reg.sync2[rtcc_pkg::SY_WAIT])
					st_next.wstate = rtcc_pkg::RTCC_HOLD; // R14
			rtcc_pkg::RTCC_HOLD:
				if (!st_reg.sync2[rtcc_pkg::SY_WAIT])
					st_next.wstate = rtcc_pkg::RTCC_DRAIN; // R14
			rtcc_pkg::RTCC_DRAIN:
				if (st_reg.sync2[rtcc_pkg::SY_WAIT])
					st_next.wstate = rtcc_pkg::RTCC_HOLD;
				else if (!counter_write_busy)
					st_next.wstate = rtcc_pkg::RTCC_RUN; // R17
			default:
				st_next.wstate = rtcc_pkg::RTCC_RUN;
		endcase
		// Seconds carry; a carry during wait is parked, a seconds write drops it
		if (st_reg.wstate == rtcc_pkg::RTCC_HOLD)
		begin
			if (ovf)
				st_next.pend_ovf = 1'b1; // R16
			if (second_write)
				st_next.pend_ovf = 1'b0; // R16
		end
		else if (st_reg.pend_ovf)
		begin
			st_next.sec_up = 1'b1; // R16
			st_next.pend_ovf = 1'b0; // R16
		end
		else
			st_next.sec_up = ovf; // R14
		// Fixed-cycle period select
		unique case (st_reg.ctrl1[rtcc_pkg::SEL_MSB:rtcc_pkg::SEL_LSB])
			rtcc_pkg::FC_NONE:
				fc_hit = 1'b0; // R12
			rtcc_pkg::FC_HALF_SEC:
				fc_hit = tick & running & ((st_reg.presc & rtcc_pkg::HALF_SEC_MASK) ==
					rtcc_pkg::HALF_SEC_MASK); // R12
			rtcc_pkg::FC_SECOND:
				fc_hit = st_next.sec_up; // R12
			rtcc_pkg::FC_MINUTE:
				fc_hit = minute_start; // R12
			rtcc_pkg::FC_HOUR:
				fc_hit = hour_start; // R12
			rtcc_pkg::FC_DAY:
				fc_hit = day_start; // R12
			default:
				fc_hit = month_start; // R12
		endcase
		// Interrupts and pins are silenced in backup mode; counting goes on
		st_next.irqs.fixed_cycle = fc_hit & ~backup_mode_set; // R12 R22
		st_next.irqs.alarm = alarm_match & st_reg.ctrl2[rtcc_pkg::ALARM_EN_BIT] &
			~backup_mode_set; // R13 R22
		st_next.irqs.interval = tick & running & st_reg.ctrl3[rtcc_pkg::INT_EN_BIT] &
			((st_reg.presc & int_mask) == int_mask) & ~backup_mode_set; // R18 R21 R22
		st_next.pins.one_hz = st_reg.sync2[rtcc_pkg::SY_ONE_HZ] &
			st_reg.presc[rtcc_pkg::ONE_HZ_TAP] & ~backup_mode_set; // R8 R22
		st_next.pins.clk32k = st_reg.sync2[rtcc_pkg::SY_CLK32K] & sub_clk &
			~backup_mode_set; // R9 R22
		st_next.pins.div = st_reg.sync2[rtcc_pkg::SY_DIV_EN] & ~backup_mode_set &
			(st_reg.sync2[rtcc_pkg::SY_DIV_SEL] ? st_reg.presc[rtcc_pkg::DIV_16K_TAP] :
			st_reg.presc[rtcc_pkg::DIV_512_TAP]); // R19 R20 R22
	end

	// Only the backup-domain power-on reset clears state; no other reset enters here
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg <= '0; // R5
			st_reg.ctrl0 <= rtcc_pkg::CTRL_RESET; // R5
			st_reg.ctrl1 <= rtcc_pkg::CTRL_RESET; // R5
			st_reg.ctrl2 <= rtcc_pkg::CTRL_RESET; // R5
			st_reg.ctrl3 <= rtcc_pkg::CTRL_RESET; // R5
			st_reg.wstate <= rtcc_pkg::RTCC_RUN;
		end
		else
			st_reg <= st_next;
	end

	assign rd_data = st_reg.rdata;
	assign pins = st_reg.pins;
	assign irqs = st_reg.irqs;
	assign sec_count_up = st_reg.sec_up;
	assign counter_hold = (st_reg.wstate == rtcc_pkg::RTCC_HOLD); // R14
	assign time_count_en = running & ~counter_hold; // R6 R14
	assign rtc_power_on = st_reg.ctrl0[rtcc_pkg::POWER_ON_BIT]; // R1
	assign count_clock_select = st_reg.ctrl0[rtcc_pkg::CLK_SEL_BIT]; // R2
	assign hour_format_24 = st_reg.ctrl1[rtcc_pkg::HOUR24_BIT]; // R10

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_power_off_clears: assert property (!rtc_power_on |=> st_reg.presc == 15'h0000) // R1
		else $error("prescaler not cleared while powered off");
	a_select_sub_tick: assert property (!count_clock_select && sub_clk && !st_reg.sub_prev
		|-> tick) // R2
		else $error("subclock edge did not make a tick");
	a_regs_retained: assert property (!bus_req.wr |=> $stable(st_reg.ctrl1) &&
		$stable(st_reg.ctrl3)) // R5
		else $error("control register changed without a write");
	a_run_gates_presc: assert property (rtc_power_on && !st_reg.ctrl1[rtcc_pkg::RUN_BIT]
		|=> $stable(st_reg.presc)) // R6
		else $error("prescaler moved while run bit clear");
	a_one_hz_low: assert property (!st_reg.sync2[rtcc_pkg::SY_ONE_HZ] |=> !pins.one_hz) // R8
		else $error("one hertz pin high while disabled");
	a_clk32k_off: assert property (!st_reg.sync2[rtcc_pkg::SY_CLK32K] |=> !pins.clk32k) // R9
		else $error("clock pin active while disabled");
	a_alarm_gate: assert property (alarm_match && st_reg.ctrl2[rtcc_pkg::ALARM_EN_BIT] &&
		!backup_mode_set |=> irqs.alarm) // R13
		else $error("alarm interrupt missing");
	a_wait_drain_hold: assert property (st_reg.wstate == rtcc_pkg::RTCC_DRAIN &&
		counter_write_busy |=> wait_status) // R17
		else $error("wait status dropped during counter write");
	a_wait_status_read: assert property (bus_req.rd && bus_req.addr == rtcc_pkg::ADDR_ALARM_WAIT
		|=> rd_data[rtcc_pkg::WAIT_STAT_BIT] == $past(wait_status)) // R15
		else $error("wait status read wrong");
	a_pend_discard: assert property (st_reg.wstate == rtcc_pkg::RTCC_HOLD && second_write
		|=> !st_reg.pend_ovf) // R16
		else $error("parked carry survived a seconds write");
	a_pend_apply: assert property (st_reg.pend_ovf && st_reg.wstate != rtcc_pkg::RTCC_HOLD
		|=> sec_count_up ##1 !st_reg.pend_ovf) // R16
		else $error("parked carry not applied");
	a_interval_gate: assert property (!st_reg.ctrl3[rtcc_pkg::INT_EN_BIT] |=> !irqs.interval) // R18
		else $error("interval interrupt while disabled");
	a_div_low: assert property (!st_reg.sync2[rtcc_pkg::SY_DIV_EN] |=> !pins.div) // R20
		else $error("divided pin active while disabled");
	a_backup_silent: assert property (backup_mode_set |=> irqs == 3'h0 && pins == 3'h0) // R22
		else $error("output active in backup mode");

	a_presc_counts: assert property (running && tick |=>
		st_reg.presc == $past(st_reg.presc) + 15'h0001) // R6
		else $error("prescaler missed a counting tick");
	a_backup_counting: assert property (backup_mode_set && running && tick |=>
		st_reg.presc == $past(st_reg.presc) + 15'h0001) // R22
		else $error("counting stopped in backup mode");
	a_sync_stage: assert property (tick |=> st_reg.sync2 == $past(st_reg.sync1)) // R23
		else $error("staging flops did not advance on a tick");
	a_sync_hold: assert property (!tick |=> $stable(st_reg.sync2)) // R23
		else $error("staging flops moved without a tick");
	a_wait_enter: assert property (st_reg.wstate == rtcc_pkg::RTCC_RUN &&
		st_reg.sync2[rtcc_pkg::SY_WAIT] |=> counter_hold) // R14
		else $error("wait request did not halt counting");
	a_hold_stops_count: assert property (counter_hold |-> !time_count_en) // R14
		else $error("time counting enabled during wait");
	a_hold_no_carry: assert property (counter_hold |=> !sec_count_up) // R16
		else $error("seconds carry issued during wait");
	a_drain_release: assert property (st_reg.wstate == rtcc_pkg::RTCC_DRAIN &&
		!st_reg.sync2[rtcc_pkg::SY_WAIT] && !counter_write_busy |=> !wait_status) // R17
		else $error("wait status stuck after writes finished");
	a_half_sec_irq: assert property (st_reg.ctrl1[rtcc_pkg::SEL_MSB:rtcc_pkg::SEL_LSB] ==
		rtcc_pkg::FC_HALF_SEC && tick && running && st_reg.presc[13:0] == 14'h3fff &&
		!backup_mode_set |=> irqs.fixed_cycle) // R12
		else $error("half second interrupt missing");
	a_fc_none_quiet: assert property (st_reg.ctrl1[rtcc_pkg::SEL_MSB:rtcc_pkg::SEL_LSB] ==
		rtcc_pkg::FC_NONE |=> !irqs.fixed_cycle) // R12
		else $error("fixed-cycle interrupt while unused");
	a_alarm_off: assert property (!st_reg.ctrl2[rtcc_pkg::ALARM_EN_BIT] |=> !irqs.alarm) // R13
		else $error("alarm interrupt while disabled");
	a_div_fast: assert property (st_reg.sync2[rtcc_pkg::SY_DIV_EN] &&
		st_reg.sync2[rtcc_pkg::SY_DIV_SEL] && !backup_mode_set |=>
		pins.div == $past(st_reg.presc[rtcc_pkg::DIV_16K_TAP])) // R19
		else $error("divided pin not at fast rate");
	a_div_slow: assert property (st_reg.sync2[rtcc_pkg::SY_DIV_EN] &&
		!st_reg.sync2[rtcc_pkg::SY_DIV_SEL] && !backup_mode_set |=>
		pins.div == $past(st_reg.presc[rtcc_pkg::DIV_512_TAP])) // R19
		else $error("divided pin not at slow rate");
	a_one_hz_follow: assert property (st_reg.sync2[rtcc_pkg::SY_ONE_HZ] && !backup_mode_set
		|=> pins.one_hz == $past(st_reg.presc[rtcc_pkg::ONE_HZ_TAP])) // R8
		else $error("one hertz pin not following prescaler");
	a_clk32k_follow: assert property (st_reg.sync2[rtcc_pkg::SY_CLK32K] && !backup_mode_set
		|=> pins.clk32k == $past(sub_clk)) // R9
		else $error("clock pin not following subclock");
	a_interval_top: assert property (st_reg.ctrl3[rtcc_pkg::SEL_MSB:rtcc_pkg::SEL_LSB] >=
		rtcc_pkg::INTERVAL_TOP_SEL |-> int_mask == 15'h0fff) // R21
		else $error("top interval codes not at longest period");
	a_interval_low: assert property (st_reg.ctrl3[rtcc_pkg::SEL_MSB:rtcc_pkg::SEL_LSB] ==
		3'h0 |-> int_mask == 15'h003f) // R21
		else $error("shortest interval period wrong");

	c_div_toggle: cover property (pins.div ##1 !pins.div);
	c_wait_cycle: cover property (st_reg.wstate == rtcc_pkg::RTCC_HOLD ##1
		st_reg.wstate == rtcc_pkg::RTCC_DRAIN);
	c_pend_applied: cover property (st_reg.pend_ovf ##1 sec_count_up);
	c_interval_irq: cover property (irqs.interval);
	c_fixed_irq: cover property (irqs.fixed_cycle);
endmodule

// *** pkg/rtcc_pkg.sv ***
// Constants, types and register layout for the real-time counter control block
package rtcc_pkg;
	localparam logic [31:0] ADDR_POWER_CLOCK = 32'h0ffffadd;
	localparam logic [31:0] ADDR_INTERVAL_OUT = 32'h0ffffae0;
	localparam logic [31:0] ADDR_RUN_OUT_CYCLE = 32'hfffffade;
	localparam logic [31:0] ADDR_ALARM_WAIT = 32'hfffffadf;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MASK_POWER_CLOCK = 8'hc0;
	localparam logic [7:0] MASK_RUN_OUT_CYCLE = 8'hbf;
	localparam logic [7:0] MASK_ALARM_WAIT = 8'h81;
	localparam logic [7:0] MASK_INTERVAL_OUT = 8'he7;
	localparam int unsigned POWER_ON_BIT = 7;
	localparam int unsigned CLK_SEL_BIT = 6;
	localparam int unsigned RUN_BIT = 7;
	localparam int unsigned ONE_HZ_BIT = 5;
	localparam int unsigned CLK32K_BIT = 4;
	localparam int unsigned HOUR24_BIT = 3;
	localparam int unsigned ALARM_EN_BIT = 7;
	localparam int unsigned WAIT_STAT_BIT = 1;
	localparam int unsigned WAIT_REQ_BIT = 0;
	localparam int unsigned INT_EN_BIT = 7;
	localparam int unsigned DIV_EN_BIT = 6;
	localparam int unsigned DIV_FREQ_BIT = 5;
	localparam int unsigned SEL_MSB = 2;
	localparam int unsigned SEL_LSB = 0;
	localparam logic [2:0] FC_NONE = 3'h0;
	localparam logic [2:0] FC_HALF_SEC = 3'h1;
	localparam logic [2:0] FC_SECOND = 3'h2;
	localparam logic [2:0] FC_MINUTE = 3'h3;
	localparam logic [2:0] FC_HOUR = 3'h4;
	localparam logic [2:0] FC_DAY = 3'h5;
	localparam logic [2:0] INTERVAL_TOP_SEL = 3'h6;
	localparam int unsigned PRESC_W = 15;
	localparam int unsigned ONE_HZ_TAP = 14;
	localparam int unsigned DIV_512_TAP = 5;
	localparam int unsigned DIV_16K_TAP = 0;
	localparam logic [14:0] INTERVAL_BASE = 15'h0040;
	localparam logic [14:0] HALF_SEC_MASK = 15'h3fff;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned SYNC_TICKS = 2;
	localparam int unsigned SY_WAIT = 0;
	localparam int unsigned SY_ONE_HZ = 1;
	localparam int unsigned SY_CLK32K = 2;
	localparam int unsigned SY_DIV_EN = 3;
	localparam int unsigned SY_DIV_SEL = 4;
	localparam int unsigned SY_W = 5;
	typedef enum logic [2:0] {
		RTCC_RUN = 3'b001,
		RTCC_HOLD = 3'b010,
		RTCC_DRAIN = 3'b100
	} rtcc_wait_e;
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rtcc_bus_req_s;
	typedef struct packed {
		logic one_hz;
		logic clk32k;
		logic div;
	} rtcc_pins_s;
	typedef struct packed {
		logic fixed_cycle;
		logic alarm;
		logic interval;
	} rtcc_irqs_s;
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] ctrl3;
		logic [7:0] rdata;
		logic [14:0] presc;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic sub_prev;
		logic brg_prev;
		rtcc_wait_e wstate;
		logic pend_ovf;
		logic sec_up;
		rtcc_pins_s pins;
		rtcc_irqs_s irqs;
	} rtcc_state_s;
endpackage

// *** verif/rtcc_ctrl_tb.sv ***
// Self-checking bench for the real-time counter control registers
`timescale 1ns/1ps
module rtcc_ctrl_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	rtcc_pkg::rtcc_bus_req_s bus_req = '0;
	logic [7:0] rd_data;
	logic sub_clk = 1'b0;
	logic brg_clk = 1'b0;
	logic sub_run = 1'b0;
	logic brg_run = 1'b0;
	logic backup_mode_set = 1'b0;
	logic [4:0] ev = '0;
	logic second_write = 1'b0;
	logic counter_write_busy = 1'b0;
	rtcc_pkg::rtcc_pins_s pins;
	rtcc_pkg::rtcc_irqs_s irqs;
	logic sec_count_up, time_count_en, counter_hold;
	logic rtc_power_on, count_clock_select, hour_format_24;
	int n_fail = 0;
	int comparisons = 0;
	logic [31:0] adr [4] = '{rtcc_pkg::ADDR_POWER_CLOCK, rtcc_pkg::ADDR_RUN_OUT_CYCLE,
		rtcc_pkg::ADDR_ALARM_WAIT, rtcc_pkg::ADDR_INTERVAL_OUT};
	logic [7:0] msk [4] = '{rtcc_pkg::MASK_POWER_CLOCK, rtcc_pkg::MASK_RUN_OUT_CYCLE,
		rtcc_pkg::MASK_ALARM_WAIT, rtcc_pkg::MASK_INTERVAL_OUT};
	// Random data never sets run, power or wait, so software rules stay kept
	logic [7:0] safe [4] = '{8'h40, 8'h7f, 8'h80, 8'hff};
	logic [7:0] shadow [4] = '{8'h00, 8'h00, 8'h00, 8'h00};

	rtcc_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
		.sub_clk(sub_clk), .brg_clk(brg_clk), .backup_mode_set(backup_mode_set),
		.alarm_match(ev[4]), .minute_start(ev[0]), .hour_start(ev[1]), .day_start(ev[2]),
		.month_start(ev[3]), .second_write(second_write),
		.counter_write_busy(counter_write_busy), .pins(pins), .irqs(irqs),
		.sec_count_up(sec_count_up), .time_count_en(time_count_en),
		.counter_hold(counter_hold), .rtc_power_on(rtc_power_on),
		.count_clock_select(count_clock_select), .hour_format_24(hour_format_24));

	always #5 ref_clk = ~ref_clk;

	// Count clocks toggle every cycle to keep tick-based waits short
	always @(posedge ref_clk)
	begin
		if (sub_run)
			sub_clk <= ~sub_clk;
		if (brg_run)
			brg_clk <= ~brg_clk;
	end

	task automatic give_verdict;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		cmp8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic cmpn(input int got, input int exp);
		comparisons++;
		if (got != exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input int r, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{adr[r], d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
		shadow[r] = d & msk[r];
	endtask

	task automatic rd(input logic [31:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		@(negedge ref_clk);
		d = rd_data;
	endtask

	task automatic wait_stat(input logic want);
		logic [7:0] d;
		int i;
		for (i = 0; i < 40; i++)
		begin
			rd(adr[2], d);
			if (d[1] === want)
				break;
		end
		if (i == 40)
		begin
			n_fail++;
			give_verdict();
		end
		cmp1(d[1], want);
	endtask

	// Transitions of the divided pin (w=1) or the 32 kHz pin over 40 cycles
	task automatic edges(input int w, output int k);
		logic p, c;
		k = 0;
		p = w ? pins.div : pins.clk32k;
		repeat (40)
		begin
			@(negedge ref_clk);
			c = w ? pins.div : pins.clk32k;
			k += int'(c !== p);
			p = c;
		end
	endtask

	task automatic fire(input int i, output rtcc_pkg::rtcc_irqs_s seen);
		seen = '0;
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		@(posedge ref_clk);
		ev[i] <= 1'b0;
		repeat (3)
		begin
			@(negedge ref_clk);
			seen = seen | irqs;
		end
	endtask

	task automatic gap(output int n);
		int i;
		for (i = 0; i < 3000 && irqs.interval !== 1'b1; i++)
			@(negedge ref_clk);
		@(negedge ref_clk);
		for (n = 1; n < 3000 && irqs.interval !== 1'b1; n++)
			@(negedge ref_clk);
		if (i == 3000 || n == 3000)
		begin
			n_fail++;
			give_verdict();
		end
	endtask

	initial
	begin
		logic [7:0] d;
		logic e;
		rtcc_pkg::rtcc_irqs_s s;
		int k, r, c, i, b;
		void'($urandom(74069));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		for (r = 0; r < 4; r++)
		begin
			rd(adr[r], d);
			cmp8(d, 8'h00);
		end
		for (k = 0; k < 8; k++)
		begin
			r = k % 4;
			wr(r, 8'($urandom()) & safe[r]);
			rd(adr[r], d);
			cmp8(d, shadow[r]);
		end
		cmp1(count_clock_select, shadow[0][6]);
		cmp1(hour_format_24, shadow[1][3]);
		rd(32'h0ffffade, d);
		cmp8(d, 8'h00);
		wr(1, 8'h00);
		wr(2, 8'h00);
		wr(3, 8'h60);
		wr(0, 8'h40);
		wr(0, 8'hc0);
		wr(1, 8'h80);
		@(negedge ref_clk);
		cmp1(rtc_power_on, 1'b1);
		cmp1(time_count_en, 1'b1);
		sub_run <= 1'b1;
		repeat (10) @(negedge ref_clk);
		edges(1, k);
		cmpn(k, 0);
		brg_run <= 1'b1;
		repeat (10) @(negedge ref_clk);
		edges(1, k);
		cmpn(k, 20);
		wr(3, 8'h40);
		repeat (10) @(negedge ref_clk);
		edges(1, k);
		cmpn(int'(k <= 1), 1);
		wr(3, 8'h00);
		repeat (10) @(negedge ref_clk);
		edges(1, k);
		cmpn(k, 0);
		cmp1(pins.div, 1'b0);
		brg_run <= 1'b0;
		wr(0, 8'h40);
		wr(0, 8'h00);
		wr(0, 8'h80);
		wr(1, 8'h90);
		repeat (10) @(negedge ref_clk);
		edges(0, k);
		cmpn(k, 40);
		cmp1(pins.one_hz, 1'b0);
		@(posedge ref_clk);
		backup_mode_set <= 1'b1;
		repeat (4) @(negedge ref_clk);
		edges(0, k);
		cmpn(k, 0);
		@(posedge ref_clk);
		backup_mode_set <= 1'b0;
		wr(1, 8'h80);
		repeat (10) @(negedge ref_clk);
		edges(0, k);
		cmpn(k, 0);
		for (c = 0; c < 3; c++)
		begin
			wr(3, 8'h80 | 8'(c));
			gap(k);
			cmpn(k, (64 << c) * 2);
		end
		wr(3, 8'h02);
		e = 1'b0;
		repeat (300)
		begin
			@(negedge ref_clk);
			e = e | irqs.interval;
		end
		cmp1(e, 1'b0);
		wr(2, 8'h80);
		for (b = 0; b < 2; b++)
		begin
			@(posedge ref_clk);
			backup_mode_set <= 1'(b);
			for (c = 0; c < 8; c++)
			begin
				wr(1, 8'h80 | 8'(c));
				for (i = 0; i < 5; i++)
				begin
					fire(i, s);
					e = (c == 3 && i == 0) || (c == 4 && i == 1) || (c == 5 && i == 2);
					e = b == 0 && (e || (c >= 6 && i == 3));
					cmp1(s.fixed_cycle, e);
					cmp1(s.alarm, b == 0 && i == 4);
				end
			end
		end
		@(posedge ref_clk);
		backup_mode_set <= 1'b0;
		wr(2, 8'h00);
		fire(4, s);
		cmp1(s.alarm, 1'b0);
		wr(2, 8'h01);
		wait_stat(1'b1);
		cmp1(counter_hold, 1'b1);
		cmp1(time_count_en, 1'b0);
		@(posedge ref_clk);
		counter_write_busy <= 1'b1;
		wr(2, 8'h00);
		repeat (20) @(posedge ref_clk);
		rd(adr[2], d);
		cmp8(d, 8'h02);
		@(posedge ref_clk);
		counter_write_busy <= 1'b0;
		wait_stat(1'b0);
		cmp1(counter_hold, 1'b0);
		cmp1(sec_count_up, 1'b0);
		@(posedge ref_clk);
		rst <= 1'b1;
		@(posedge ref_clk);
		rst <= 1'b0;
		for (r = 0; r < 4; r++)
		begin
			rd(adr[r], d);
			cmp8(d, 8'h00);
		end
		give_verdict();
	end
endmodule
